//--- rtl/reset_escalation_defs.svh
// Constants for the chip-side reset sequencer and its source collector.
// Assumes a 20 MHz system clock; all counts derive from the figures below.
`ifndef RESET_ESCALATION_DEFS_SVH
`define RESET_ESCALATION_DEFS_SVH

`define CLK_PERIOD_NS 50
`define RST_HOLD_NS 1000
`define RST_HOLD_CYCLES ((`RST_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_CNT_W 8

`define CAUSE_W 7
`define SRC_W 6
`define CAUSE_POR 0
`define CAUSE_WARM_PIN 1
`define CAUSE_SW_COLD 2
`define CAUSE_SW_WARM 3
`define CAUSE_WATCHDOG 4
`define CAUSE_THERMAL 5
`define CAUSE_SECURITY 6

`endif

//--- rtl/reset_escalation_pkg.sv
// Types shared by the reset sequencer and the source collector.
// Assumes reset_escalation_defs.svh supplies the widths.
`include "reset_escalation_defs.svh"

package reset_escalation_pkg;

	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_POR_HOLD = 2'b01,
		ST_WARM_HOLD = 2'b10
	} seq_state_t;

	typedef logic [`CAUSE_W-1:0] cause_t;
	typedef logic [`SRC_W-1:0] src_vec_t;

	typedef struct packed {
		logic active;
		src_vec_t cause;
	} collector_state_t;

	typedef struct packed {
		seq_state_t state;
		logic [`HOLD_CNT_W-1:0] count;
		logic sys_reset_out_n;
		logic core_reset;
		cause_t cause;
		logic boot_hang_risk;
		logic boot_alt_order;
		logic eth_reset_isolate;
		logic supply_off;
	} seq_state_reg_t;

endpackage

//--- rtl/reset_source_if.sv
// Carries the gathered non-power-on reset request and its cause bits.
// Assumes one collector drives it and one sequencer reads it.
`timescale 1ns/10ps
`default_nettype none

interface reset_source_if;
	import reset_escalation_pkg::*;
	logic active;
	src_vec_t cause;
	modport src (output active, output cause);
	modport sink (input active, input cause);
endinterface

`default_nettype wire

//--- rtl/reset_source_collector.sv
// Gathers every non-power-on reset source of the chip into one request.
// Assumes all source inputs are synchronous to clock.
`timescale 1ns/10ps
`default_nettype none

module reset_source_collector (
	input wire logic clock,
	input wire logic rst,
	input wire logic warm_reset_in_n,
	input wire logic sw_cold_reset_req,
	input wire logic sw_warm_reset_req,
	input wire logic watchdog_expired,
	input wire logic thermal_shutdown,
	input wire logic security_violation,
	reset_source_if.src req
);
	import reset_escalation_pkg::*;

	collector_state_t r_reg;
	collector_state_t r_next;
	src_vec_t raw;

	always_comb begin
		raw = '0;
		raw[`CAUSE_WARM_PIN-1] = ~warm_reset_in_n;
		raw[`CAUSE_SW_COLD-1] = sw_cold_reset_req;
		raw[`CAUSE_SW_WARM-1] = sw_warm_reset_req;
		raw[`CAUSE_WATCHDOG-1] = watchdog_expired;
		raw[`CAUSE_THERMAL-1] = thermal_shutdown;
		raw[`CAUSE_SECURITY-1] = security_violation;
		r_next.cause = raw;
		r_next.active = |raw;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign req.active = r_reg.active;
	assign req.cause = r_reg.cause;

endmodule

`default_nettype wire

//--- rtl/reset_escalation_to_por.sv
// Chip-side reset sequencer: drives the system reset output for every reset source.
// Assumes synchronous inputs, a 20 MHz clock and an outside pulse generator on porz.
`timescale 1ns/10ps
`default_nettype none

module reset_escalation_to_por (
	input wire logic clock,
	input wire logic rst,
	input wire logic power_on_reset_n,
	input wire logic warm_reset_in_n,
	input wire logic sw_cold_reset_req,
	input wire logic sw_warm_reset_req,
	input wire logic watchdog_expired,
	input wire logic thermal_shutdown,
	input wire logic security_violation,
	input wire logic eth_isolate_enable,
	input wire logic boot_reorder_enable,
	input wire logic sw_power_off_req,
	input wire logic supply_hold_in,
	output logic sys_reset_out_n,
	output logic core_reset,
	output reset_escalation_pkg::cause_t reset_cause_status,
	output logic boot_hang_risk,
	output logic boot_alt_order,
	output logic eth_reset_isolate,
	output logic supply_off
);
	import reset_escalation_pkg::*;

	localparam logic [`HOLD_CNT_W-1:0] HOLD_LOAD = `HOLD_CNT_W'(`RST_HOLD_CYCLES - 1);

	seq_state_reg_t r_reg;
	seq_state_reg_t r_next;

	reset_source_if src_bus ();

	reset_source_collector collector (
		.clock(clock),
		.rst(rst),
		.warm_reset_in_n(warm_reset_in_n),
		.sw_cold_reset_req(sw_cold_reset_req),
		.sw_warm_reset_req(sw_warm_reset_req),
		.watchdog_expired(watchdog_expired),
		.thermal_shutdown(thermal_shutdown),
		.security_violation(security_violation),
		.req(src_bus.src)
	);

	always_comb begin
		r_next = r_reg;
		// Supply hold high locks the supplies on; only the companion can cut them
		r_next.supply_off = sw_power_off_req & ~supply_hold_in;
		if (!power_on_reset_n) begin
			// Power-on reset wipes all warm-reset history
			r_next.state = ST_POR_HOLD;
			r_next.count = HOLD_LOAD;
			r_next.core_reset = 1'b1;
			r_next.sys_reset_out_n = 1'b0;
			r_next.cause = '0;
			r_next.cause[`CAUSE_POR] = 1'b1;
			r_next.eth_reset_isolate = 1'b0;
			r_next.boot_alt_order = 1'b0;
			r_next.boot_hang_risk = 1'b0;
		end else begin
			case (r_reg.state)
				ST_RUN: begin
					if (src_bus.active) begin
						r_next.state = ST_WARM_HOLD;
						r_next.count = HOLD_LOAD;
						r_next.core_reset = 1'b1;
						r_next.sys_reset_out_n = 1'b0;
						r_next.cause = {src_bus.cause, 1'b0};
						// Ethernet is held out of this warm reset only when asked
						r_next.eth_reset_isolate = eth_isolate_enable;
					end
				end
				ST_WARM_HOLD: begin
					// Late sources add to the cause; during the hold only power-on reset drops a set bit
					r_next.cause = r_reg.cause | {src_bus.cause, 1'b0};
					if (r_reg.count != '0) begin
						r_next.count = r_reg.count - 1'b1;
					end else if (!src_bus.active) begin
						r_next.state = ST_RUN;
						r_next.core_reset = 1'b0;
						r_next.sys_reset_out_n = 1'b1;
						r_next.eth_reset_isolate = 1'b0;
						// Warm release boots in a state that may hang
						r_next.boot_hang_risk = 1'b1;
						r_next.boot_alt_order = boot_reorder_enable;
					end
				end
				ST_POR_HOLD: begin
					if (r_reg.count != '0) begin
						r_next.count = r_reg.count - 1'b1;
					end else begin
						r_next.state = ST_RUN;
						r_next.core_reset = 1'b0;
						r_next.sys_reset_out_n = 1'b1;
					end
				end
				default: begin
					r_next.state = ST_POR_HOLD;
					r_next.count = HOLD_LOAD;
					r_next.core_reset = 1'b1;
					r_next.sys_reset_out_n = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			r_reg <= '0;
			r_reg.state <= ST_POR_HOLD;
			r_reg.count <= HOLD_LOAD;
			r_reg.core_reset <= 1'b1;
			r_reg.cause <= `CAUSE_W'(1 << `CAUSE_POR);
		end else begin
			r_reg <= r_next;
		end
	end

	assign sys_reset_out_n = r_reg.sys_reset_out_n;
	assign core_reset = r_reg.core_reset;
	assign reset_cause_status = r_reg.cause;
	assign boot_hang_risk = r_reg.boot_hang_risk;
	assign boot_alt_order = r_reg.boot_alt_order;
	assign eth_reset_isolate = r_reg.eth_reset_isolate;
	assign supply_off = r_reg.supply_off;

endmodule

`default_nettype wire

//--- verif/reset_escalation_to_por_monitor.sv
// Checker for the reset sequencer outputs.
// Assumes it is bound to the sequencer top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module reset_escalation_to_por_monitor (
	input wire logic clock,
	input wire logic rst,
	input wire logic power_on_reset_n,
	input wire logic thermal_shutdown,
	input wire logic sw_power_off_req,
	input wire logic supply_hold_in,
	input wire logic sys_reset_out_n,
	input wire reset_escalation_pkg::cause_t reset_cause_status,
	input wire logic boot_hang_risk,
	input wire logic boot_alt_order,
	input wire logic eth_reset_isolate,
	input wire logic supply_off
);
	logic [7:0] low_reg;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// Saturates, so a long power-on hold cannot wrap into a short one;
	// cleared by rst so the first release after power-up sees a real count
	always_ff @(posedge clock)
		low_reg <= (rst || sys_reset_out_n) ? 8'h00 : low_reg + {7'h00, low_reg != 8'hFF};
	sequence entry;
		##2 !sys_reset_out_n;
	endsequence
	src_entry_a: assert property (thermal_shutdown && sys_reset_out_n |-> entry)
		else $error("no reset entry");
	thermal_cause_a: assert property (
		thermal_shutdown && sys_reset_out_n |-> entry ##0 reset_cause_status[5])
		else $error("thermal cause missing");
	// Counted from the first edge that sees the output low
	hold_min_a: assert property ($rose(sys_reset_out_n) |-> low_reg >= 8'h13)
		else $error("reset output too short");
	hang_flag_a: assert property (
		$rose(sys_reset_out_n) |-> boot_hang_risk == !reset_cause_status[0])
		else $error("hang flag wrong");
	cause_clear_a: assert property (!power_on_reset_n |=> reset_cause_status == 7'h01)
		else $error("cause kept");
	esc_flags_a: assert property (
		!power_on_reset_n |=> !eth_reset_isolate && !boot_alt_order && !boot_hang_risk)
		else $error("flags kept");
	supply_lock_a: assert property (sw_power_off_req && supply_hold_in |=> !supply_off)
		else $error("supply not locked");
	supply_off_a: assert property (sw_power_off_req && !supply_hold_in |=> supply_off)
		else $error("supply not off");
endmodule
bind reset_escalation_to_por reset_escalation_to_por_monitor i_monitor (.clock, .rst,
	.power_on_reset_n, .thermal_shutdown, .sw_power_off_req, .supply_hold_in,
	.sys_reset_out_n, .reset_cause_status, .boot_hang_risk, .boot_alt_order,
	.eth_reset_isolate, .supply_off);
`default_nettype wire

//--- verif/por_pulse_gen.sv
// Pulse generator that turns each reset output assertion into a power-on pulse.
// Assumes the sequencer clock; the pulse is a whole number of its cycles.
`timescale 1ns/10ps
`default_nettype none
module por_pulse_gen #(
	parameter int PULSE_LEN = 12
) (
	input wire logic clock,
	input wire logic sys_reset_out_n,
	output logic power_on_reset_n
);
	int count = 0;
	logic armed = 1'b1;
	always @(posedge clock) begin
		if (count != 0) begin
			count <= count - 1;
		end else if (!sys_reset_out_n && armed) begin
			count <= PULSE_LEN;
			armed <= 1'b0;
		end else if (sys_reset_out_n) begin
			armed <= 1'b1;
		end
	end
	assign power_on_reset_n = (count == 0);
endmodule
`default_nettype wire

//--- verif/reset_escalation_to_por_bench.sv
// Bench for the reset sequencer with the pulse generator closing the loop.
// Assumes the checker binds itself to the sequencer.
`timescale 1ns/10ps
`default_nettype none
module reset_escalation_to_por_bench;
	import reset_escalation_pkg::*;
	localparam int PULSE = 12;
	logic clock = 1'b0, rst = 1'b1, eth_en = 1'b0, reord = 1'b0, off_req = 1'b0, hold = 1'b0;
	logic [5:0] src = 6'h00;
	logic por_n, sys_n, core, hang, alt, eth, off;
	cause_t cause;
	int fail_count = 0, checked = 0, seed = 32'hABEC, cycles = 0, n, i, k, len;
	always #25 clock = ~clock;
	por_pulse_gen #(.PULSE_LEN(PULSE)) i_por_pulse_gen (.clock, .sys_reset_out_n(sys_n),
		.power_on_reset_n(por_n));
	reset_escalation_to_por i_reset_escalation_to_por (.clock, .rst, .power_on_reset_n(por_n),
		.warm_reset_in_n(!src[0]), .sw_cold_reset_req(src[1]), .sw_warm_reset_req(src[2]),
		.watchdog_expired(src[3]), .thermal_shutdown(src[4]), .security_violation(src[5]),
		.eth_isolate_enable(eth_en), .boot_reorder_enable(reord), .sw_power_off_req(off_req),
		.supply_hold_in(hold), .sys_reset_out_n(sys_n), .core_reset(core),
		.reset_cause_status(cause), .boot_hang_risk(hang), .boot_alt_order(alt),
		.eth_reset_isolate(eth), .supply_off(off));
	task automatic step;
		@(posedge clock);
		#5;
	endtask
	task automatic cmp(input logic [10:0] got, input logic [10:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_release;
		len = 0;
		while (sys_n !== 1'b1 && len < 400) begin
			step;
			len++;
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			complete_run;
		end
	end
	initial begin
		repeat (20) step;
		rst = 1'b0;
		wait_release;
		cmp({cause, hang, alt, eth, core}, 11'h010);
		$display("test reset done");
		for (i = 0; i < 6; i++) begin
			eth_en = 1'($random(seed));
			reord = 1'($random(seed));
			src[i] = 1'b1;
			n = 0;
			while (sys_n !== 1'b0 && n < 8) begin
				step;
				n++;
			end
			cmp(11'(n), 11'h002);
			cmp({2'b0, eth, cause, core}, {2'b0, eth_en, 7'(1 << (i + 1)), 1'b1});
			// Source stays up a few cycles, so the pulse overlaps a live request
			k = 1 + ($random(seed) & 3);
			repeat (k) step;
			src[i] = 1'b0;
			wait_release;
			cmp(11'(len + k + n >= PULSE + 20), 11'h001);
			cmp({cause, hang, alt, eth, core}, 11'h010);
			$display("test source %0d done", i);
		end
		for (k = 0; k < 4; k++) begin
			{off_req, hold} = k[1:0];
			step;
			cmp(11'(off), 11'(off_req & !hold));
		end
		$display("test supply done");
		complete_run;
	end
endmodule
`default_nettype wire
